// [inc/ctd_defines.svh]
`ifndef CTD_DEFINES_SVH
`define CTD_DEFINES_SVH

// ==========================================================
// task set and program counter
`define CTD_NUM_TASKS 8
`define CTD_PC_W 12
`define CTD_PIPE_STAGES 8
`define CTD_STOP_OPCODE 32'h1f80_0000

// ==========================================================
// trigger source select codes, two bits per task
`define CTD_SRC_NONE 2'h0
`define CTD_SRC_CONV 2'h1
`define CTD_SRC_ALT 2'h2
`define CTD_SRC_ENCCAP 2'h3

// ==========================================================
// message memories, word addresses
`define CTD_MSG_WORDS 128
`define CTD_MSG_MASK 16'hff80
`define CTD_A2C_BASE 16'h1480
`define CTD_C2A_BASE 16'h1500

// ==========================================================
// register write and debug read selects
`define CTD_RF_AUX0 3'h4
`define CTD_RF_AUX1 3'h5
`define CTD_RF_FSTAT 3'h6
`define CTD_DBG_PC 3'h0
`define CTD_DBG_AUX0 3'h1
`define CTD_DBG_AUX1 3'h2
`define CTD_DBG_FSTAT 3'h3

`endif

// [inc/ctd_pkg.sv]
package ctd_pkg;

  typedef enum logic [1:0] {
    CTD_IDLE,
    CTD_RUN,
    CTD_DRAIN
  } ctd_state_e;

  typedef struct packed {
    ctd_state_e state;
    logic [7:0] pend;
    logic [2:0] cur_task;
    logic [11:0] pc;
    logic fetch;
    logic rd_d;
    logic [7:0] stop_pipe;
    logic [7:0] done_irq;
    logic running;
    logic [17:0] irq_prev;
    logic [3:0][31:0] res;
    logic [15:0] aux0;
    logic [15:0] aux1;
    logic [31:0] fstat;
    logic [31:0] dbg_rdata;
    logic [15:0] core_rdata;
    logic [15:0] acc_rdata;
    logic per_req;
    logic per_we;
    logic [15:0] per_addr;
    logic [15:0] per_wdata;
    logic owner_core;
  } ctd_state_s;

endpackage

// [design/ctd_dispatch.sv]
// Functional notes
// (R1) runs entirely on sys_clk, the main core clock; no divider, no second domain.
// (R2) eight tasks, each an interrupt service routine in accelerator program memory.
// (R3) a launched task fetches first from its own start vector.
// (R4) pc wraps freely; task length bounded only by program memory size.
// (R5) one task at a time, run to completion, no preemption or nesting.
// (R6) each task end pulses its own completion interrupt to the expansion block.
// (R7) at task end the highest-priority pending task launches automatically.
// (R8) core interrupt-ack instruction triggers any task as a software request.
// (R9) tasks one to seven take numbered converter or modulator interrupts.
// (R10) tasks four and seven also accept encoder or capture interrupts.
// (R11) task eight takes converter eight, system timer zero, or encoder/capture.
// (R12) program memory addressed by a 12-bit program counter.
// (R13) four 32-bit result registers plus a floating-point status register.
// (R14) two 16-bit auxiliary registers for data addressing.
// (R15) own program and data buses feeding an eight-stage pipeline.
// (R16) single-precision arithmetic incl. parallel load/store results land in the result file.
// (R17) parallel multiply/add and reciprocal estimates write back through the same port.
// (R18) two message memories, one per direction between accelerator and core.
// (R19) core software selects whether memories belong to core or accelerator space.
// (R20) accelerator reaches peripheral registers directly over its own data bus.
// (R21) core sees pc, auxiliary, status, result registers read-only; writes ignored.
// (R22) accelerator-to-core message memory: 128 words from 0x1480.
// (R23) core-to-accelerator message memory: 128 words from 0x1500.
// (R24) lower task number wins among simultaneously pending tasks.
// (R25) trigger for a running or pending task only sets pending, never restarts.
`include "ctd_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module ctd_dispatch
  import ctd_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // trigger sources, levels
  input wire logic [7:0] conv_irq,
  input wire logic [6:0] mod_irq,
  input wire logic encoder_irq,
  input wire logic capture_irq,
  input wire logic timer0_irq,
  input wire logic [15:0] task_src_sel,
  // interrupt-ack instruction from the core
  input wire logic sw_trig_valid,
  input wire logic [2:0] sw_trig_task,
  // start vectors, 12 bits per task
  input wire logic [95:0] task_start_vector,
  // memory ownership
  input wire logic map_to_core,
  output logic mem_owner_core,
  // program bus
  output logic [11:0] prog_addr,
  output logic prog_rd,
  input wire logic [31:0] prog_data,
  // task status and completion toward the expansion block
  output logic [7:0] task_done_irq,
  output logic task_running,
  output logic [2:0] task_current,
  // result writeback from the execution units
  input wire logic rf_we,
  input wire logic [2:0] rf_sel,
  input wire logic [31:0] rf_wdata,
  // core debug read port
  input wire logic [2:0] dbg_sel,
  output logic [31:0] dbg_rdata,
  // core data port to message memories
  input wire logic [15:0] core_addr,
  input wire logic core_we,
  input wire logic [15:0] core_wdata,
  output logic [15:0] core_rdata,
  // accelerator data bus
  input wire logic acc_req,
  input wire logic acc_we,
  input wire logic [15:0] acc_addr,
  input wire logic [15:0] acc_wdata,
  output logic [15:0] acc_rdata,
  // direct peripheral access
  output logic periph_req,
  output logic periph_we,
  output logic [15:0] periph_addr,
  output logic [15:0] periph_wdata,
  input wire logic periph_rvalid,
  input wire logic [15:0] periph_rdata
);

  // ========================================================
  // reset synchroniser
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ========================================================
  // trigger edges and per-task source selection
  logic [17:0] irq_now;
  logic [17:0] irq_rise;
  logic [7:0] hw_trig;

  assign irq_now = {timer0_irq, capture_irq, encoder_irq, mod_irq, conv_irq};

  ctd_state_s st_r;
  ctd_state_s st_nxt;

  // levels become one event per rising edge so a held line cannot re-fire
  assign irq_rise = irq_now & ~st_r.irq_prev;

  genvar gt;
  generate
    for (gt = 0; gt < `CTD_NUM_TASKS; gt++) begin : g_trig
      logic [1:0] sel;
      logic alt;
      logic enccap;
      assign sel = task_src_sel[2*gt+1:2*gt];
      // task eight's alternative source is system timer zero
      if (gt == 7) begin : g_t8
        assign alt = irq_rise[17]; // R11
      end else begin : g_tn
        assign alt = irq_rise[8+gt]; // R9
      end
      if (gt == 3 || gt == 6 || gt == 7) begin : g_ec
        assign enccap = irq_rise[15] | irq_rise[16]; // R10
      end else begin : g_noec
        assign enccap = 1'b0;
      end
      assign hw_trig[gt] = (sel == `CTD_SRC_CONV) ? irq_rise[gt] :
                           (sel == `CTD_SRC_ALT) ? alt :
                           (sel == `CTD_SRC_ENCCAP) ? enccap : 1'b0; // R9 R11
    end
  endgenerate

  // ========================================================
  // message memories
  logic [15:0] mem_a2c [0:`CTD_MSG_WORDS-1];
  logic [15:0] mem_c2a [0:`CTD_MSG_WORDS-1];
  logic core_hit_a2c;
  logic core_hit_c2a;
  logic acc_hit_a2c;
  logic acc_hit_c2a;

  assign core_hit_a2c = (core_addr & `CTD_MSG_MASK) == `CTD_A2C_BASE; // R22
  assign core_hit_c2a = (core_addr & `CTD_MSG_MASK) == `CTD_C2A_BASE; // R23
  assign acc_hit_a2c = (acc_addr & `CTD_MSG_MASK) == `CTD_A2C_BASE; // R22
  assign acc_hit_c2a = (acc_addr & `CTD_MSG_MASK) == `CTD_C2A_BASE; // R23

  // each direction has one writer, so no arbitration is needed
  always_ff @(posedge sys_clk) begin
    if (core_we && core_hit_c2a) begin
      mem_c2a[core_addr[6:0]] <= core_wdata; // R18
    end
    if (acc_req && acc_we && acc_hit_a2c) begin
      mem_a2c[acc_addr[6:0]] <= acc_wdata; // R18
    end
  end

  // ========================================================
  // dispatcher, pipeline tracking and register file
  logic [7:0] sw_trig;
  logic [7:0] pend_clr;
  logic [2:0] pick;
  logic launch;
  logic stop_now;

  always_comb begin
    st_nxt = st_r;
    pick = 3'h0;
    sw_trig = sw_trig_valid ? 8'(8'h01 << sw_trig_task) : 8'h00; // R8
    st_nxt.irq_prev = irq_now;
    st_nxt.done_irq = 8'h00;
    st_nxt.per_req = 1'b0;
    st_nxt.owner_core = map_to_core; // R19
    // descending scan leaves the lowest pending number in pick
    for (int i = `CTD_NUM_TASKS - 1; i >= 0; i--) begin
      if (st_r.pend[i]) begin
        pick = 3'(i); // R24
      end
    end
    launch = (st_r.state == CTD_IDLE) && (|st_r.pend) && !st_r.owner_core; // R5 R7
    pend_clr = launch ? 8'(8'h01 << pick) : 8'h00;
    // set after clear: a trigger in the launch cycle stays pending
    st_nxt.pend = (st_r.pend & ~pend_clr) | hw_trig | sw_trig; // R25
    stop_now = (st_r.state == CTD_RUN) && st_r.rd_d && (prog_data == `CTD_STOP_OPCODE);
    st_nxt.rd_d = st_r.fetch;
    st_nxt.stop_pipe = {st_r.stop_pipe[`CTD_PIPE_STAGES-2:0], stop_now}; // R15
    case (st_r.state)
      CTD_IDLE: begin
        if (launch) begin
          st_nxt.cur_task = pick;
          st_nxt.pc = task_start_vector[12*pick +: 12]; // R3
          st_nxt.fetch = 1'b1;
          st_nxt.running = 1'b1;
          st_nxt.state = CTD_RUN; // R2
        end
      end
      CTD_RUN: begin
        if (st_r.fetch) begin
          st_nxt.pc = st_r.pc + 12'h001; // R4 R12
        end
        if (stop_now) begin
          st_nxt.fetch = 1'b0;
          st_nxt.state = CTD_DRAIN;
        end
      end
      CTD_DRAIN: begin
        // completion only once the stop has left the last stage
        if (st_r.stop_pipe[`CTD_PIPE_STAGES-1]) begin
          st_nxt.done_irq = 8'(8'h01 << st_r.cur_task); // R6
          st_nxt.running = 1'b0;
          st_nxt.state = CTD_IDLE; // R7
        end
      end
      default: begin
        st_nxt.state = CTD_IDLE;
        st_nxt.fetch = 1'b0;
        st_nxt.running = 1'b0;
      end
    endcase
    // the only writer of the register file is the execution side
    if (rf_we) begin
      case (rf_sel)
        `CTD_RF_AUX0: st_nxt.aux0 = rf_wdata[15:0]; // R14
        `CTD_RF_AUX1: st_nxt.aux1 = rf_wdata[15:0]; // R14
        `CTD_RF_FSTAT: st_nxt.fstat = rf_wdata; // R13
        default: begin
          if (!rf_sel[2]) begin
            st_nxt.res[rf_sel[1:0]] = rf_wdata; // R13 R16 R17
          end
        end
      endcase
    end
    // core debug view has no write path at all
    case (dbg_sel)
      `CTD_DBG_PC: st_nxt.dbg_rdata = {20'h0_0000, st_r.pc}; // R21
      `CTD_DBG_AUX0: st_nxt.dbg_rdata = {16'h0000, st_r.aux0}; // R21
      `CTD_DBG_AUX1: st_nxt.dbg_rdata = {16'h0000, st_r.aux1}; // R21
      `CTD_DBG_FSTAT: st_nxt.dbg_rdata = st_r.fstat; // R21
      default: st_nxt.dbg_rdata = st_r.res[dbg_sel[1:0]]; // R21
    endcase
    st_nxt.core_rdata = core_hit_a2c ? mem_a2c[core_addr[6:0]] :
                        core_hit_c2a ? mem_c2a[core_addr[6:0]] : 16'h0000; // R18
    if (acc_req && (acc_hit_a2c || acc_hit_c2a)) begin
      st_nxt.acc_rdata = acc_hit_c2a ? mem_c2a[acc_addr[6:0]] : mem_a2c[acc_addr[6:0]];
    end else if (acc_req) begin
      st_nxt.per_req = 1'b1; // R20
      st_nxt.per_we = acc_we;
      st_nxt.per_addr = acc_addr;
      st_nxt.per_wdata = acc_wdata;
    end
    if (periph_rvalid) begin
      st_nxt.acc_rdata = periph_rdata; // R20
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r <= '0; // R1
      st_r.owner_core <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ========================================================
  // outputs
  assign mem_owner_core = st_r.owner_core;
  assign prog_addr = st_r.pc;
  assign prog_rd = st_r.fetch;
  assign task_done_irq = st_r.done_irq;
  assign task_running = st_r.running;
  assign task_current = st_r.cur_task;
  assign dbg_rdata = st_r.dbg_rdata;
  assign core_rdata = st_r.core_rdata;
  assign acc_rdata = st_r.acc_rdata;
  assign periph_req = st_r.per_req;
  assign periph_we = st_r.per_we;
  assign periph_addr = st_r.per_addr;
  assign periph_wdata = st_r.per_wdata;

endmodule // ctd_dispatch

`default_nettype wire

// [verification/ctd_dispatch_props.sv]
`timescale 1ns/100ps
`default_nettype none
// ====
// dispatch checker
module ctd_dispatch_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // requests
  input wire logic sw_trig_valid,
  input wire logic map_to_core,
  input wire logic [95:0] task_start_vector,
  input wire logic acc_req,
  input wire logic [15:0] acc_addr,
  // responses
  input wire logic mem_owner_core,
  input wire logic [11:0] prog_addr,
  input wire logic prog_rd,
  input wire logic [7:0] task_done_irq,
  input wire logic task_running,
  input wire logic [2:0] task_current,
  input wire logic periph_req,
  input wire logic [15:0] periph_addr
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_done;
    task_done_irq != 8'h0;
  endsequence
  sequence s_launch;
    $rose(task_running);
  endsequence
  done_own_task_a: assert property (s_done |-> task_done_irq == (8'h1 << task_current))
    else $error("completion bit not the finished task");
  done_pulse_a: assert property (s_done |=> task_done_irq == 8'h0)
    else $error("completion longer than one cycle");
  done_ends_run_a: assert property (s_done |-> !task_running && $past(task_running))
    else $error("completion without a finished run");
  launch_vector_a: assert property (s_launch |-> prog_rd && prog_addr == task_start_vector[task_current*12 +: 12])
    else $error("launch not at start vector");
  no_preempt_a: assert property (task_running && $past(task_running) |-> $stable(task_current))
    else $error("running task replaced");
  pc_step_a: assert property (prog_rd && $past(prog_rd) |-> prog_addr == 12'($past(prog_addr) + 12'h1))
    else $error("fetch address jumped");
  sw_launch_a: assert property (sw_trig_valid && !task_running && !map_to_core && !mem_owner_core |-> ##[1:3] task_running)
    else $error("software request not launched");
  owner_blocks_a: assert property (mem_owner_core && !task_running |=> !task_running)
    else $error("launch while memories owned by core");
  periph_fwd_a: assert property (acc_req && (acc_addr < 16'h1480 || acc_addr > 16'h157f) |=> periph_req && periph_addr == $past(acc_addr))
    else $error("peripheral access not forwarded");
endmodule // ctd_dispatch_props

bind ctd_dispatch ctd_dispatch_props ctd_dispatch_props_i (.*);
`default_nettype wire

// [verification/ctd_prog_model.sv]
`include "ctd_defines.svh"
`timescale 1ns/100ps
`default_nettype none
// ====
// program memory: every word whose low three address bits are 3 holds the stop opcode
module ctd_prog_model (
  // clock
  input wire logic sys_clk,
  // program bus
  input wire logic [11:0] prog_addr,
  input wire logic prog_rd,
  output logic [31:0] prog_data
);
  initial prog_data = 32'h0;
  always @(posedge sys_clk) begin
    if (prog_rd) begin
      prog_data <= (prog_addr[2:0] == 3'h3) ? `CTD_STOP_OPCODE : {20'h0, prog_addr};
    end else begin
      // released bus must not keep showing the last word
      prog_data <= ~prog_data;
    end
  end
endmodule // ctd_prog_model
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // ====
  // signals
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [17:0] irq_v = 18'h0;
  logic [7:0] conv_irq;
  logic [6:0] mod_irq;
  logic encoder_irq, capture_irq, timer0_irq;
  logic [15:0] task_src_sel = 16'h0;
  logic sw_trig_valid = 1'b0;
  logic [2:0] sw_trig_task = 3'h0;
  logic [95:0] task_start_vector;
  logic map_to_core = 1'b0;
  logic mem_owner_core, prog_rd, task_running, periph_req, periph_we;
  logic [11:0] prog_addr;
  logic [31:0] prog_data, dbg_rdata;
  logic [7:0] task_done_irq;
  logic [2:0] task_current;
  logic rf_we = 1'b0;
  logic [2:0] rf_sel = 3'h0;
  logic [2:0] dbg_sel = 3'h0;
  logic [31:0] rf_wdata = 32'h0;
  logic core_we = 1'b0;
  logic acc_req = 1'b0;
  logic acc_we = 1'b0;
  logic periph_rvalid = 1'b0;
  logic [15:0] core_addr = 16'h0;
  logic [15:0] core_wdata = 16'h0;
  logic [15:0] acc_addr = 16'h0;
  logic [15:0] acc_wdata = 16'h0;
  logic [15:0] periph_rdata = 16'h0;
  logic [15:0] core_rdata, acc_rdata, periph_addr, periph_wdata;
  logic [7:0] done_q[$];
  logic [31:0] rs = 32'hfed3;
  logic run_d = 1'b0;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  assign {timer0_irq, capture_irq, encoder_irq, mod_irq, conv_irq} = irq_v;
  always #2 sys_clk = ~sys_clk;
  ctd_dispatch ctd_dispatch_i (.*);
  ctd_prog_model ctd_prog_model_i (.*);
  // ====
  // helpers
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // task eight wraps the counter past fff
  function automatic logic [11:0] vec(input logic [2:0] t);
    return t == 3'h7 ? 12'hffe : {t, 9'h0a0};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic summarize();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // level held a few cycles must still count once
  task automatic fire(input int b);
    @(posedge sys_clk);
    irq_v[b] <= 1'b1;
    repeat (3) @(posedge sys_clk);
    irq_v[b] <= 1'b0;
  endtask
  task automatic sw(input logic [2:0] t);
    @(posedge sys_clk);
    sw_trig_valid <= 1'b1;
    sw_trig_task <= t;
    @(posedge sys_clk);
    sw_trig_valid <= 1'b0;
  endtask
  task automatic wait_done(input int n);
    for (int i = 0; i < 300 && done_q.size() < n; i++) begin
      @(posedge sys_clk);
    end
    chk(done_q.size(), n, "done count");
  endtask
  task automatic mem(input logic acc, input logic we, input logic [15:0] a, input logic [15:0] wd,
                     output logic [15:0] r);
    @(posedge sys_clk);
    acc_req <= acc;
    acc_we <= we;
    acc_addr <= a;
    acc_wdata <= wd;
    core_we <= we & ~acc;
    core_addr <= a;
    core_wdata <= wd;
    @(posedge sys_clk);
    acc_req <= 1'b0;
    core_we <= 1'b0;
    #1;
    r = acc ? acc_rdata : core_rdata;
  endtask
  // ====
  // monitor and timeout
  always @(posedge sys_clk) begin
    run_d <= task_running;
    cyc <= cyc + 1;
    if (task_done_irq !== 8'h0) begin
      done_q.push_back(task_done_irq);
    end
    if (task_running === 1'b1 && run_d === 1'b0) begin
      chk(prog_addr, vec(task_current), "vector");
    end
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  // ====
  // scenarios
  initial begin
    logic [1:0] code;
    logic [7:0] m;
    logic [31:0] d;
    logic [15:0] r, o;
    int b, k;
    for (int t = 0; t < 8; t++) task_start_vector[12*t +: 12] = vec(3'(t));
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int t = 0; t < 8; t++) begin
      code = (t == 3 || t == 6 || t == 7) ? 2'(rnd() % 3 + 1) : 2'(rnd() % 2 + 1);
      b = code == 2'h1 ? t : code == 2'h2 ? (t == 7 ? 17 : 8 + t) : 15 + int'(rnd() % 2);
      @(posedge sys_clk);
      task_src_sel <= 16'(code) << (2 * t);
      fire(b);
      wait_done(t + 1);
      chk(done_q[t], 8'h1 << t, "done bit");
    end
    fire(0);
    repeat (20) @(posedge sys_clk);
    chk(done_q.size(), 8, "unselected source");
    task_src_sel <= 16'h5555;
    m = 8'(rnd()) | 8'h81;
    @(posedge sys_clk);
    irq_v[7:0] <= m;
    k = done_q.size();
    wait_done(k + $countones(m));
    for (int i = 0; i < 8; i++) begin
      if (m[i]) begin
        chk(done_q[k], 8'h1 << i, "order");
        k++;
      end
    end
    task_src_sel <= 16'h0;
    irq_v <= 18'h0;
    sw(3'h2);
    repeat (3) @(posedge sys_clk);
    sw(3'h2);
    wait_done(k + 2);
    chk(done_q[k], 8'h04, "sw run");
    chk(done_q[k+1], 8'h04, "rerun");
    map_to_core <= 1'b1;
    sw(3'h5);
    repeat (20) @(posedge sys_clk);
    #1;
    chk(task_running, 1'b0, "blocked");
    chk(mem_owner_core, 1'b1, "owner");
    @(posedge sys_clk);
    map_to_core <= 1'b0;
    wait_done(k + 3);
    chk(done_q[k+2], 8'h20, "released");
    // last task stops at its fourth word; the word after it was already requested
    @(posedge sys_clk);
    dbg_sel <= 3'h0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(dbg_rdata, {20'h0_0000, vec(3'h5) + 12'h005}, "debug pc");
    for (int s = 0; s < 7; s++) begin
      d = rnd();
      @(posedge sys_clk);
      rf_we <= 1'b1;
      rf_sel <= 3'(s);
      rf_wdata <= d;
      dbg_sel <= s < 4 ? 3'(s + 4) : 3'(s - 3);
      @(posedge sys_clk);
      rf_we <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk(dbg_rdata, (s == 4 || s == 5) ? {16'h0, d[15:0]} : d, "debug");
    end
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      o = 16'(rnd() % 128);
      mem(1'b0, 1'b1, 16'h1500 + o, d[15:0], r);
      mem(1'b1, 1'b1, 16'h1500 + o, d[31:16], r);
      mem(1'b1, 1'b0, 16'h1500 + o, 16'h0, r);
      chk(r, d[15:0], "to accel");
      mem(1'b1, 1'b1, 16'h1480 + o, d[31:16], r);
      mem(1'b0, 1'b1, 16'h1480 + o, d[15:0], r);
      mem(1'b0, 1'b0, 16'h1480 + o, 16'h0, r);
      chk(r, d[31:16], "to core");
    end
    mem(1'b1, 1'b0, 16'h7104, 16'h0, r);
    chk({periph_req, periph_we, periph_addr}, {2'b10, 16'h7104}, "periph read");
    d = rnd();
    @(posedge sys_clk);
    periph_rvalid <= 1'b1;
    periph_rdata <= d[15:0];
    @(posedge sys_clk);
    periph_rvalid <= 1'b0;
    #1;
    chk(acc_rdata, d[15:0], "periph data");
    mem(1'b1, 1'b1, 16'h7105, d[31:16], r);
    chk({periph_req, periph_we, periph_addr, periph_wdata}, {2'b11, 16'h7105, d[31:16]}, "periph write");
    summarize();
  end
endmodule // testbench
`default_nettype wire
